// >>> core/maod_core.sv
// Core: four-phase decode and execute of add-with-carry, ANDs, bit clear and branches
// Contract
// - add-with-carry sums W, carry, file; all flags
// - destination bit zero to W, one to file
// - addressing bit zero access bank, one bank register
// - extended set, a zero, f<=95: indexed offset
// - and literal into W; N and Z only
// - and file to destination; N and Z only
// - clear selected file bit; flags unchanged
// - branch when carry set; flags unchanged
// - branch when negative set; flags unchanged
// - branch when carry clear; flags unchanged
// - taken target is incremented PC plus twice offset
// - taken branch two cycles, second is no-op
module maod_core
   import maod_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] instr_i,       // Instruction word for this cycle
   input wire logic ext_set_en_i,         // Extended instruction set enabled
   input wire logic [3:0] bank_select_reg_i, // Bank number for banked access
   input wire logic [7:0] index_base_i,   // Index register low byte for indexed mode
   input wire logic [7:0] file_rdata_i,   // Data read from file address
   output logic [11:0] file_addr_o,       // Data memory address
   output logic [7:0] file_wdata_o,       // Data to write
   output logic file_we_o,                // Write strobe, one quarter
   output logic file_re_o,                // Read strobe, one quarter
   output logic [7:0] wreg_o,             // Working register
   output logic [4:0] flags_o,            // N OV Z DC C
   output logic [20:0] pc_o,              // Program counter
   output logic [1:0] phase_o,            // Current quarter
   output logic nop_cycle_o               // High through a flushed cycle
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   maod_phase_t phase;                    // Quarter counter
   logic [15:0] ir;                       // Latched instruction
   logic [7:0] opnd;                      // Operand read in second quarter
   logic [7:0] result;                    // Computed in third quarter
   logic [4:0] next_flags;                // Flags after compute
   logic wr_file, wr_w, take;             // Decided in third quarter
   logic flush;                           // Current cycle is the branch no-op
   logic [7:0] wreg;
   logic [4:0] flags;
   logic [20:0] pc;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic is_addc, is_andf, is_andl, is_clr, is_bc, is_bn, is_bnc, is_br;
   logic [11:0] eff_addr;
   logic [15:0] src;                      // Word the address is decoded from
   logic [8:0] sum;
   logic [4:0] lo_sum;
   assign is_addc = (ir[15:10] == OPC_ADD_CARRY);
   assign is_andf = (ir[15:10] == OPC_AND_FILE);
   assign is_andl = (ir[15:8] == OPC_AND_LIT);
   assign is_clr = (ir[15:12] == OPC_CLR_BIT);
   assign is_bc = (ir[15:8] == OPC_BR_CARRY);
   assign is_bn = (ir[15:8] == OPC_BR_NEG);
   assign is_bnc = (ir[15:8] == OPC_BR_NOCARRY);
   assign is_br = is_bc | is_bn | is_bnc;

   // In decode the incoming word steers the address, so it stands through the read quarter
   assign src = (phase == PH_DECODE) ? instr_i : ir;

   // Address select; indexed offset wraps within one bank, a known limitation
   always_comb begin
      if (src[ABIT]) begin
         eff_addr = {bank_select_reg_i, src[7:0]};
      end else if (ext_set_en_i && (src[7:0] <= IDX_LIMIT)) begin
         eff_addr = {BANK_RST, 8'(index_base_i + src[7:0])};
      end else if (src[7:0] >= ACCESS_SPLIT) begin
         eff_addr = {ACCESS_HI_BANK, src[7:0]};
      end else begin
         eff_addr = {BANK_RST, src[7:0]};
      end
   end

   // Adder with carry in; half carry from the low nibble
   assign sum = {1'b0, wreg} + {1'b0, opnd} + {8'h00, flags[FL_C]};
   assign lo_sum = {1'b0, wreg[3:0]} + {1'b0, opnd[3:0]} + {4'h0, flags[FL_C]};

   // ----------------------------------------
   // Quarter sequencer
   // ----------------------------------------
   // Free-running: every instruction cycle is four clocks
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase <= PH_DECODE;
      end else begin
         case (phase)
            PH_DECODE: phase <= PH_READ;
            PH_READ: phase <= PH_PROC;
            PH_PROC: phase <= PH_WRITE;
            PH_WRITE: phase <= PH_DECODE;
            default: phase <= PH_DECODE;
         endcase
      end
   end

   // ----------------------------------------
   // Decode and operand fetch
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ir <= 16'h0000;
         opnd <= 8'h00;
      end else begin
         if (phase == PH_DECODE) begin
            ir <= instr_i;
         end
         if (phase == PH_READ) begin
            // Literal forms take the low byte, file forms the read data
            opnd <= (is_andl || is_br) ? ir[7:0] : file_rdata_i;
         end
      end
   end

   // ----------------------------------------
   // Compute in third quarter
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         result <= 8'h00;
         next_flags <= FLAGS_RST;
         wr_file <= 1'b0;
         wr_w <= 1'b0;
         take <= 1'b0;
      end else if (phase == PH_PROC) begin
         result <= 8'h00;
         next_flags <= flags;
         wr_file <= 1'b0;
         wr_w <= 1'b0;
         take <= 1'b0;
         if (flush) begin
            // Second cycle of a taken branch does nothing
            result <= 8'h00;
         end else if (is_addc) begin
            result <= sum[7:0];
            next_flags[FL_C] <= sum[8];
            next_flags[FL_DC] <= lo_sum[4];
            next_flags[FL_Z] <= (sum[7:0] == 8'h00);
            next_flags[FL_N] <= sum[7];
            next_flags[FL_OV] <= (wreg[7] == opnd[7]) && (sum[7] != wreg[7]);
            wr_file <= ir[DEST_BIT];
            wr_w <= ~ir[DEST_BIT];
         end else if (is_andl || is_andf) begin
            result <= wreg & opnd;
            next_flags[FL_Z] <= ((wreg & opnd) == 8'h00);
            next_flags[FL_N] <= wreg[7] & opnd[7];
            wr_w <= is_andl | ~ir[DEST_BIT];
            wr_file <= is_andf & ir[DEST_BIT];
         end else if (is_clr) begin
            result <= opnd & ~(8'h01 << ir[BITSEL_LSB +: 3]);
            wr_file <= 1'b1;
         end else if (is_br) begin
            take <= (is_bc & flags[FL_C]) | (is_bn & flags[FL_N])
               | (is_bnc & ~flags[FL_C]);
         end
      end
   end

   // ----------------------------------------
   // Write back in fourth quarter
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wreg <= W_RST;
         flags <= FLAGS_RST;
         pc <= PC_RST;
         flush <= 1'b0;
      end else if (phase == PH_WRITE) begin
         if (wr_w) begin
            wreg <= result;
         end
         flags <= next_flags;
         if (take && !flush) begin
            // Step PC past this word, then add twice the offset
            pc <= pc + PC_STEP + {{12{opnd[7]}}, opnd, 1'b0};
            flush <= 1'b1;
         end else begin
            pc <= pc + PC_STEP;
            flush <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Memory strobes, registered outputs
   // ----------------------------------------
   // Address is taken at the decode edge and holds until the next decode edge
   // Write strobe rises after the write quarter, once the result register has settled
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         file_addr_o <= 12'h000;
         file_re_o <= 1'b0;
         file_we_o <= 1'b0;
         file_wdata_o <= 8'h00;
      end else begin
         file_addr_o <= eff_addr;
         file_re_o <= (phase == PH_DECODE) && !flush;
         file_we_o <= (phase == PH_WRITE) && wr_file;
         file_wdata_o <= result;
      end
   end

   // Mirrors of internal state
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wreg_o <= W_RST;
         flags_o <= FLAGS_RST;
         pc_o <= PC_RST;
         phase_o <= 2'h0;
         nop_cycle_o <= 1'b0;
      end else begin
         wreg_o <= wreg;
         flags_o <= flags;
         pc_o <= pc;
         phase_o <= phase;
         nop_cycle_o <= flush;
      end
   end
endmodule

// >>> pkg/maod_pkg.sv
// Package: encodings, field positions, flag layout and phase states for the op decoder
package maod_pkg;
   // ----------------------------------------
   // Opcode patterns (upper bits of the 16-bit word)
   // ----------------------------------------
   localparam logic [5:0] OPC_ADD_CARRY = 6'h08;  // 0010 00da
   localparam logic [5:0] OPC_AND_FILE = 6'h05;   // 0001 01da
   localparam logic [7:0] OPC_AND_LIT = 8'h0B;    // 0000 1011
   localparam logic [3:0] OPC_CLR_BIT = 4'h9;     // 1001 bbba
   localparam logic [7:0] OPC_BR_CARRY = 8'hE2;   // 1110 0010
   localparam logic [7:0] OPC_BR_NEG = 8'hE6;     // 1110 0110
   localparam logic [7:0] OPC_BR_NOCARRY = 8'hE3; // 1110 0011
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int DEST_BIT = 9;
   localparam int ABIT = 8;
   localparam int BITSEL_LSB = 9;
   localparam logic [7:0] IDX_LIMIT = 8'h5F;      // Indexed offset applies at or below
   // ----------------------------------------
   // Status flag positions and reset values
   // ----------------------------------------
   localparam int FL_C = 0;
   localparam int FL_DC = 1;
   localparam int FL_Z = 2;
   localparam int FL_OV = 3;
   localparam int FL_N = 4;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;  // Access bank upper half
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   // ----------------------------------------
   // Quarter-cycle phases
   // ----------------------------------------
   typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} maod_phase_t;
endpackage

// >>> verif/maod_monitor.sv
// Checker: timing relations among the op decoder outputs
module maod_monitor
   import maod_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic file_we_o,
   input wire logic file_re_o,
   input wire logic [20:0] pc_o,
   input wire logic [7:0] wreg_o,
   input wire logic [4:0] flags_o,
   input wire logic [1:0] phase_o,
   input wire logic nop_cycle_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // One instruction cycle is four clocks, so pc rests three
   sequence s_pc_quiet;
      !$changed(pc_o) [*3];
   endsequence
   // A flushed cycle lasts one instruction cycle, then drops
   sequence s_nop_span;
      nop_cycle_o [*4] ##1 !nop_cycle_o;
   endsequence
   a_pc_even: assert property (pc_o[0] == 1'b0)
      else $error("pc odd");
   a_pc_once: assert property ($changed(pc_o) |=> s_pc_quiet)
      else $error("pc moved twice in a cycle");
   // W and flags only move on an instruction boundary, where pc moves too
   a_state_boundary: assert property (
      $changed(wreg_o) || $changed(flags_o) |-> $changed(pc_o))
      else $error("state moved off boundary");
   // Two clocks after reset the quarter counter must step
   a_phase_steps: assert property (
      !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> phase_o == $past(phase_o) + 2'h1)
      else $error("quarter did not step");
   a_read_pulse: assert property (file_re_o |=> !file_re_o [*3])
      else $error("read strobe too long");
   a_write_pulse: assert property (file_we_o |=> !file_we_o [*3])
      else $error("write strobe too long");
   // Read strobe follows decode, write strobe follows the write quarter: three clocks apart
   a_write_after_read: assert property (file_we_o |-> $past(file_re_o, 3))
      else $error("write without read");
   a_nop_quiet: assert property (nop_cycle_o |-> !file_we_o)
      else $error("write in flushed cycle");
   a_nop_span: assert property ($rose(nop_cycle_o) |-> s_nop_span)
      else $error("flushed cycle has wrong length");
endmodule

bind maod_core maod_monitor i_maod_monitor (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .file_we_o(file_we_o),
   .file_re_o(file_re_o),
   .pc_o(pc_o),
   .wreg_o(wreg_o),
   .flags_o(flags_o),
   .phase_o(phase_o),
   .nop_cycle_o(nop_cycle_o)
);

// >>> verif/tb.sv
// Testbench: random instruction stream checked against a reference model
module tb
   import maod_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int due; logic [7:0] w; logic [4:0] fl; logic [20:0] pc;} maod_exp_t;
   logic clk_i, sys_rst_i, ext_set_en_i, file_we_o, file_re_o, nop_cycle_o;
   logic [15:0] instr_i;
   logic [3:0] bank_select_reg_i;
   logic [7:0] index_base_i, file_rdata_i, wreg_o, file_wdata_o;
   logic [11:0] file_addr_o;
   logic [4:0] flags_o;
   logic [20:0] pc_o;
   logic [1:0] phase_o;
   logic [7:0] w; // Reference W, flags and pc
   logic [4:0] fl;
   logic [20:0] pc;
   logic [31:0] seed = 32'h0001808D;
   maod_exp_t eq[$]; // Notes of expected state per cycle
   logic [19:0] wq[$]; // Notes of expected writes
   maod_exp_t e;
   logic [19:0] wx;
   int cyc = 0, n_fail = 0, cmp_count = 0;
   maod_core i_maod_core (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .instr_i(instr_i),
      .ext_set_en_i(ext_set_en_i),
      .bank_select_reg_i(bank_select_reg_i),
      .index_base_i(index_base_i),
      .file_rdata_i(file_rdata_i),
      .file_addr_o(file_addr_o),
      .file_wdata_o(file_wdata_o),
      .file_we_o(file_we_o),
      .file_re_o(file_re_o),
      .wreg_o(wreg_o),
      .flags_o(flags_o),
      .pc_o(pc_o),
      .phase_o(phase_o),
      .nop_cycle_o(nop_cycle_o)
   );
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Effective address; the indexed window wraps within 8 bits
   function automatic logic [11:0] ea(logic a, logic [7:0] f, logic x, logic [3:0] b,
      logic [7:0] ib);
      if (a) return {b, f};
      if (x && f <= IDX_LIMIT) return {4'h0, ib + f};
      return {(f < ACCESS_SPLIT) ? BANK_RST : ACCESS_HI_BANK, f};
   endfunction
   task automatic chk(string nm, logic [20:0] want, logic [20:0] got);
      cmp_count++;
      if (got !== want) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", nm, want, got);
      end
   endtask
   // Present one word for four clocks; due edge is seven clocks on
   task automatic exec(logic [15:0] op, logic [7:0] rd);
      instr_i <= op;
      file_rdata_i <= rd;
      eq.push_back('{cyc + 7, w, fl, pc});
      repeat (4) @(posedge clk_i);
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Cycle count, with a ceiling well above the expected run
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         final_report();
      end
   end
   // Result watcher: oldest note is compared when its slot arrives
   always @(posedge clk_i) begin
      if (eq.size() > 0 && eq[0].due == cyc) begin
         e = eq.pop_front();
         chk("wreg", 21'(e.w), 21'(wreg_o));
         chk("flags", 21'(e.fl), 21'(flags_o));
         chk("pc", e.pc, pc_o);
      end
      if (file_we_o === 1'b1) begin
         wx = (wq.size() > 0) ? wq.pop_front() : 20'hFFFFF;
         chk("addr", 21'(wx[19:8]), 21'(file_addr_o));
         chk("wdata", 21'(wx[7:0]), 21'(file_wdata_o));
      end
   end
   initial begin
      logic [31:0] r;
      logic [7:0] f, rd, res, n;
      logic d, a, x, nz, tk;
      logic [15:0] op;
      sys_rst_i = 1'b1;
      instr_i = 16'h0000;
      ext_set_en_i = 1'b0;
      bank_select_reg_i = 4'h0;
      index_base_i = 8'h00;
      file_rdata_i = 8'h00;
      w = W_RST;
      fl = FLAGS_RST;
      pc = PC_RST;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (400) begin
         r = rnd();
         f = r[3] ? 8'h5F + 8'(r[0]) : r[15:8]; // Often on the indexed boundary
         rd = r[31:24];
         d = r[9];
         a = r[8];
         x = r[6];
         n = r[4] ? (r[5] ? 8'h80 : 8'h7F) : r[23:16];
         ext_set_en_i <= x;
         bank_select_reg_i <= r[23:20];
         index_base_i <= r[19:12];
         nz = 1'b1;
         tk = 1'b0;
         pc = pc + PC_STEP;
         case (r[30:28])
            3'h1: begin
               op = {OPC_AND_LIT, f};
               res = w & f;
               d = 1'b0;
            end
            3'h2: begin
               op = {OPC_AND_FILE, d, a, f};
               res = w & rd;
            end
            3'h3: begin
               op = {OPC_CLR_BIT, r[27:25], a, f};
               res = rd & ~(8'h01 << r[27:25]);
               d = 1'b1;
               nz = 1'b0;
            end
            3'h4, 3'h5, 3'h6: begin
               op = {(r[29:28] == 2'h0) ? OPC_BR_CARRY : (r[28] ? OPC_BR_NEG : OPC_BR_NOCARRY), n};
               tk = (r[29:28] == 2'h0) ? fl[FL_C]
                  : (r[28] ? fl[FL_N] : !fl[FL_C]);
               if (tk) pc = pc + {{12{n[7]}}, n, 1'b0};
               res = w;
               d = 1'b0;
               nz = 1'b0;
            end
            default: begin
               op = {OPC_ADD_CARRY, d, a, f};
               fl[FL_DC] = (w[3:0] + rd[3:0] + fl[FL_C]) > 5'h0F;
               {fl[FL_C], res} = w + rd + fl[FL_C];
               fl[FL_OV] = (w[7] == rd[7]) && (res[7] != w[7]);
            end
         endcase
         if (nz) begin
            fl[FL_N] = res[7];
            fl[FL_Z] = (res == 8'h00);
         end
         if (d) wq.push_back({ea(a, f, x, r[23:20], r[19:12]), res});
         else w = res;
         exec(op, rd);
         if (tk) begin
            pc = pc + PC_STEP;
            exec({OPC_AND_LIT, 8'h00}, rd);
         end
      end
      repeat (12) @(posedge clk_i);
      chk("pending", 21'h000000, 21'(eq.size() + wq.size()));
      final_report();
   end
endmodule
